// [verification/ssl_host.sv]
// Host controller and limit switch model for the speed block.
// Assumes the bench sets selection and limit levels in this module.
`timescale 1ns/1ps
module ssl_host (
    // Clock
    input  wire logic       clk,
    // Selection switches, high means on; limit inputs high while travel is allowed
    output var  logic [2:0] sel    = 3'h0,
    output var  logic       fwd_ok = 1'b1,
    output var  logic       rev_ok = 1'b1,
    // Command and encoder pulses
    output var  logic       cmd_p  = 1'b0,
    output var  logic       enc_s  = 1'b0,
    output var  logic       dir_o  = 1'b1,
    output var  logic       idx_o  = 1'b0
);
    // Sends n one-cycle pulses three idle cycles apart, index on the last.
    task automatic burst(input logic enc, input int n, input logic dir);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            cmd_p <= !enc;
            enc_s <= enc;
            dir_o <= dir;
            idx_o <= i == n - 1;
            @(posedge clk);
            cmd_p <= 1'b0;
            enc_s <= 1'b0;
            idx_o <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
endmodule // ssl_host

// [verification/ssl_top_asserts.sv]
// Checker on the speed block ports: bus answers, ramps and limit stops.
// Assumes it is bound to ssl_top and shadows the limit settings.
`timescale 1ns/1ps
`include "ssl_regs.svh"
module ssl_chk (
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst,
    // Register bus
    input wire logic [7:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_writedata,
    input wire logic                avs_waitrequest,
    // Limits and outputs
    input wire logic                forward_limit_in,
    input wire logic                reverse_limit_in,
    input wire ssl_pkg::ssl_speed_t speed_cmd_q,
    input wire logic                dyn_brake_q,
    input wire logic                coast_q,
    input wire logic                servo_lock_q
);
    logic       lim_en_q, scv_off_q, wr_ok, stop;
    logic [1:0] meth_q;
    assign wr_ok = avs_write && !avs_waitrequest;
    assign stop  = dyn_brake_q || coast_q || servo_lock_q;
    // ********
    // Shadow of the limit and S-curve settings.
    // ********
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lim_en_q  <= 1'b1;
            meth_q    <= 2'h0;
            scv_off_q <= 1'b1;
        end else if (wr_ok && avs_address == `SSL_OFF_LIMIT) begin
            lim_en_q <= avs_writedata[0];
            meth_q   <= avs_writedata[2:1];
        end else if (wr_ok && avs_address == `SSL_OFF_SCURVE) begin
            scv_off_q <= avs_writedata[15:0] == 16'h0;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_grant;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_bus_answer: assert property (s_req |=> s_grant)
        else $error("bus request not answered in one cycle");
    a_grant_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("waitrequest fell without a request");
    a_speed_range: assert property (speed_cmd_q <= `SSL_SPEED_MAX && speed_cmd_q >= `SSL_SPEED_MIN)
        else $error("speed command out of range");
    a_ramp_step: assert property (scv_off_q && !stop && !$past(stop)
        |-> (speed_cmd_q - $past(speed_cmd_q)) inside {16'hffff, 16'h0, 16'h1})
        else $error("speed command stepped");
    a_stop_zero: assert property (stop |-> speed_cmd_q == 16'sh0)
        else $error("stop output with nonzero speed");
    a_stop_kind: assert property (stop |-> {servo_lock_q, coast_q, dyn_brake_q} == 3'h1 << meth_q)
        else $error("wrong stop method output");
    a_fwd_halt: assert property (lim_en_q && $fell(forward_limit_in) && speed_cmd_q > 16'sh0
        |-> ##[1:2] (stop && speed_cmd_q == 16'sh0))
        else $error("forward motion not stopped");
    a_rev_halt: assert property (lim_en_q && $fell(reverse_limit_in) && speed_cmd_q < 16'sh0
        |-> ##[1:2] (stop && speed_cmd_q == 16'sh0))
        else $error("reverse motion not stopped");
    a_limit_off: assert property (!lim_en_q && !$past(lim_en_q) |-> !stop)
        else $error("stop output while limits disabled");
endmodule // ssl_chk
bind ssl_top ssl_chk u_chk (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_waitrequest, .forward_limit_in, .reverse_limit_in, .speed_cmd_q, .dyn_brake_q,
    .coast_q, .servo_lock_q);

// [verification/ssl_top_bench.sv]
// Bench for the speed block: registers, presets, limits, ramps, gear, encoder.
// Assumes ssl_host drives the pins and ssl_chk is bound to the design.
`timescale 1ns/1ps
`include "ssl_regs.svh"
module ssl_top_bench;
    // ********
    // Signals
    // ********
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic [7:0]          adr = 8'h00;
    logic                rd  = 1'b0;
    logic                wr  = 1'b0;
    logic [31:0]         wd  = 32'h0;
    logic [31:0]         rdat;
    ssl_pkg::ssl_speed_t spd;
    logic                wreq, brk, cst, lck, mst, mdr, ea, eb, ez, cmd_p, enc_s, dir_o, idx_o;
    logic                fwd_ok, rev_ok, ad = 1'b0, zd = 1'b0;
    logic [2:0]          sel;
    int                  error_cnt = 0, check_count = 0, na, nb, nz, nm;
    int                  pv [8] = '{40, -30, 25, -20, 15, -45, 35, -10};
    ssl_host p (.clk, .sel, .fwd_ok, .rev_ok, .cmd_p, .enc_s, .dir_o, .idx_o);
    ssl_top dut (.clk, .rst, .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_readdata(rdat), .avs_waitrequest(wreq), .preset_select_bit0(sel[0]),
        .preset_select_bit1(sel[1]), .preset_select_bit2(sel[2]), .forward_limit_in(fwd_ok),
        .reverse_limit_in(rev_ok), .cmd_pulse_in(cmd_p), .cmd_dir_in(dir_o), .enc_step_in(enc_s),
        .enc_dir_in(dir_o), .enc_index_in(idx_o), .speed_cmd_q(spd), .dyn_brake_q(brk),
        .coast_q(cst), .servo_lock_q(lck), .motor_step_q(mst), .motor_dir_q(mdr),
        .enc_a_out(ea), .enc_b_out(eb), .enc_z_out(ez));
    // Clock of 20 ns period.
    initial begin
        forever #10 clk = ~clk;
    end
    // Counts A rises, B level at each A rise, Z rises and geared steps.
    always @(posedge clk) begin
        ad <= ea;
        zd <= ez;
        if (ea && !ad) begin
            na++;
            nb += eb;
        end
        nz += ez && !zd;
        nm += mst;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One bus access held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wr  <= w;
        rd  <= !w;
        wd  <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        if (n >= 40) error_cnt++;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic seek(input int e, input int lim);
        for (int n = 0; n < lim && spd !== 16'(e); n++)
            @(posedge clk);
        chk(32'(spd), 32'(e));
    endtask
    task automatic near(input int e);
        repeat (1000) @(posedge clk);
        chk(32'(spd >= e - 1 && spd <= e + 1), 32'h1);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdchk(`SSL_OFF_LIMIT, 32'h1);
        rdchk(`SSL_OFF_DIVDEN, 32'h1);
        bus(1'b1, 8'hfc, 32'h5);
        rdchk(8'hfc, 32'h0);
        bus(1'b1, 8'h44, 32'hffff8ad0);
        rdchk(8'h44, 32'hffffb1e0);
        for (int i = 0; i < 8; i++)
            bus(1'b1, 8'h40 + 8'(4 * i), 32'(pv[i]));
        rdchk(8'h44, 32'hffffffe2);
        bus(1'b1, `SSL_OFF_MODE, 32'h1);
        for (int s = 1; s < 4; s++) begin
            bus(1'b1, `SSL_OFF_SRC, 32'(s));
            for (int i = 0; i < 8; i++) begin
                p.sel <= 3'(i);
                seek(s == 2 ? 0 : pv[s == 1 ? i % 4 : i], 300);
            end
        end
        $display("test presets done");
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, `SSL_OFF_LIMIT, 32'(2 * m + 1));
            p.sel <= 3'h0;
            seek(pv[0], 300);
            p.fwd_ok <= 1'b0;
            repeat (4) @(posedge clk);
            chk(32'(spd), 32'h0);
            chk({lck, cst, brk}, 32'(1 << m));
            p.sel <= 3'h1;
            seek(pv[1], 300);
            p.fwd_ok <= 1'b1;
            p.rev_ok <= 1'b0;
            repeat (4) @(posedge clk);
            chk(32'(spd), 32'h0);
            p.sel <= 3'h0;
            seek(pv[0], 300);
            p.rev_ok <= 1'b1;
        end
        bus(1'b1, `SSL_OFF_LIMIT, 32'h0);
        p.fwd_ok <= 1'b0;
        p.sel <= 3'h6;
        seek(pv[6], 300);
        chk({lck, cst, brk}, 32'h0);
        p.fwd_ok <= 1'b1;
        $display("test limits done");
        bus(1'b1, `SSL_OFF_DECEL, 32'h1);
        p.sel <= 3'h4;
        near(25);
        seek(pv[4], 2000);
        bus(1'b1, `SSL_OFF_ACCEL, 32'h1);
        p.sel <= 3'h0;
        near(25);
        seek(pv[0], 2000);
        bus(1'b1, `SSL_OFF_SCURVE, 32'h1);
        seek(2, 6400);
        seek(5, 6400);
        bus(1'b1, `SSL_OFF_GEARNUM, 32'h2);
        nm = 0;
        p.burst(1'b0, 5, 1'b1);
        repeat (8) @(posedge clk);
        chk(nm, 32'd10);
        chk(mdr, 32'h1);
        bus(1'b1, `SSL_OFF_DIVNUM, 32'h1);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, `SSL_OFF_DIVDEN, 32'(k == 1 ? 2 : 1));
            bus(1'b1, `SSL_OFF_ENCDIR, 32'(k == 3 ? 2 : k == 2));
            na = 0;
            nb = 0;
            nz = 0;
            p.burst(k != 3, k == 3 ? 8 : 16, k != 3);
            repeat (6) @(posedge clk);
            chk(na, 32'(k == 1 ? 2 : 4));
            chk(nb, 32'(k > 1 ? 4 : 0));
            chk(nz, 32'h1);
        end
        $display("test gear and encoder done");
        tally_and_finish();
    end
    // Watchdog well beyond the expected run length.
    initial begin
        #1200000;
        error_cnt++;
        tally_and_finish();
    end
endmodule // ssl_top_bench

// [verilog/ssl_enc_div.sv]
// Encoder pulse divider producing quadrature A/B and index Z.
// Assumes one step pulse per cycle at most and num not above den.
`timescale 1ns/1ps
module ssl_enc_div (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Divider link
    ssl_enc_if.div   eif
);
    logic [16:0] acc_q;
    logic [16:0] sum;
    logic [1:0]  ph_q;

    // Fractional accumulator sum for one input step.
    assign sum = acc_q + {1'b0, eif.num};

    // Divide the step stream and advance the quadrature phase.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= 17'h00000;
            ph_q  <= 2'h0;
        end else if (eif.step) begin
            if (sum >= {1'b0, eif.den}) begin
                acc_q <= sum - {1'b0, eif.den};
                ph_q  <= eif.dir ? ph_q + 2'h1 : ph_q - 2'h1;
            end else begin
                acc_q <= sum;
            end
        end
    end

    // Drive A, B and Z from flops; A leads B going up while b_invert is low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eif.a <= 1'b0;
            eif.b <= 1'b0;
            eif.z <= 1'b0;
        end else begin
            eif.a <= ph_q[1] ^ ph_q[0];
            eif.b <= ph_q[1] ^ eif.b_invert;
            eif.z <= eif.index;
        end
    end
endmodule // ssl_enc_div

// [verilog/ssl_enc_if.sv]
// Link between the top block and the encoder pulse divider.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ssl_enc_if;
    logic               step;
    logic               dir;
    logic               index;
    logic               b_invert;
    ssl_pkg::ssl_ratio_t num;
    ssl_pkg::ssl_ratio_t den;
    logic               a;
    logic               b;
    logic               z;
    modport src (output step, dir, index, b_invert, num, den, input a, b, z);
    modport div (input step, dir, index, b_invert, num, den, output a, b, z);
endinterface

// [verilog/ssl_pkg.sv]
// Types shared by the speed block and its encoder divider.
// Assumes nothing beyond a SystemVerilog compiler.
package ssl_pkg;
    typedef logic signed [15:0] ssl_speed_t;
    typedef logic [15:0]        ssl_ratio_t;
endpackage

// [verilog/ssl_regs.svh]
// Register offsets, field positions, reset values and timing counts.
// Assumes a 50 MHz clock and byte addresses on an Avalon-MM slave.
`ifndef SSL_REGS_SVH
`define SSL_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SSL_OFF_MODE     8'h00
`define SSL_OFF_SRC      8'h04
`define SSL_OFF_LIMIT    8'h08
`define SSL_OFF_ACCEL    8'h0c
`define SSL_OFF_DECEL    8'h10
`define SSL_OFF_SCURVE   8'h14
`define SSL_OFF_DIVNUM   8'h18
`define SSL_OFF_DIVDEN   8'h1c
`define SSL_OFF_ENCDIR   8'h20
`define SSL_OFF_GEARNUM  8'h24
`define SSL_OFF_GEARDEN  8'h28
`define SSL_OFF_SPEED    8'h30
`define SSL_OFF_STATUS   8'h34
`define SSL_PRESET_PAGE  3'h2

// ****************************************************************
// Field positions and encodings
// ****************************************************************
`define SSL_LIM_EN_BIT   0
`define SSL_STOP_LSB     1
`define SSL_BINV_BIT     0
`define SSL_OSRC_BIT     1
`define SSL_MODE_PRESET  3'h1
`define SSL_SRC_FOUR     2'h1
`define SSL_SRC_EIGHT    2'h3
`define SSL_STOP_BRAKE   2'h0
`define SSL_STOP_FREE    2'h1
`define SSL_STOP_LOCK    2'h2
`define SSL_SPEED_MAX    32'sh00004e20
`define SSL_SPEED_MIN    -32'sh00004e20

// ****************************************************************
// Reset values
// ****************************************************************
`define SSL_RST_RATIO    16'h0001
`define SSL_RST_LIM_EN   1'b1

// ****************************************************************
// Timing
// ****************************************************************
`define SSL_CLK_NS       20
`define SSL_RAMP_UNIT_NS 2000000
`define SSL_RAMP_RPM     1000
`define SSL_BOX_TAPS     16
`define SSL_UTICK_CYC    (`SSL_RAMP_UNIT_NS / `SSL_CLK_NS / `SSL_RAMP_RPM)
`define SSL_BOX_CYC      (`SSL_RAMP_UNIT_NS / `SSL_CLK_NS / `SSL_BOX_TAPS)

`endif

// [verilog/ssl_top.sv]
// Preset speed command generator with travel limits, gearing and
// encoder output dividing. Assumes a 50 MHz clock, synchronous inputs
// and an Avalon-MM master that holds requests until waitrequest falls.
`timescale 1ns/1ps
`include "ssl_regs.svh"

module ssl_top #(
    parameter int PRESETS  = 8,
    parameter int BOX_TAPS = `SSL_BOX_TAPS
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Avalon-MM register slave
    input  wire logic [7:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output var  logic [31:0]         avs_readdata,
    output var  logic                avs_waitrequest,
    // Preset selection and travel limits
    input  wire logic                preset_select_bit0,
    input  wire logic                preset_select_bit1,
    input  wire logic                preset_select_bit2,
    input  wire logic                forward_limit_in,
    input  wire logic                reverse_limit_in,
    // Command pulses and motor encoder
    input  wire logic                cmd_pulse_in,
    input  wire logic                cmd_dir_in,
    input  wire logic                enc_step_in,
    input  wire logic                enc_dir_in,
    input  wire logic                enc_index_in,
    // Speed command and stop outputs
    output var  ssl_pkg::ssl_speed_t speed_cmd_q,
    output var  logic                dyn_brake_q,
    output var  logic                coast_q,
    output var  logic                servo_lock_q,
    // Geared motor steps
    output var  logic                motor_step_q,
    output var  logic                motor_dir_q,
    // Divided encoder outputs
    output wire logic                enc_a_out,
    output wire logic                enc_b_out,
    output wire logic                enc_z_out
);
    localparam int UTICK = `SSL_UTICK_CYC;
    localparam int BOXC  = `SSL_BOX_CYC;
    localparam int SUMW  = 16 + $clog2(BOX_TAPS);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [2:0]           mode_q;
    logic [1:0]           src_q;
    logic                 lim_en_q;
    logic [1:0]           stop_sel_q;
    ssl_pkg::ssl_ratio_t  accel_q, decel_q, scw_q;
    ssl_pkg::ssl_ratio_t  dnum_q, dden_q, gnum_q, gden_q;
    logic [1:0]           encdir_q;
    ssl_pkg::ssl_speed_t  preset_q [PRESETS];
    logic [31:0]          rd_d;
    logic                 wr_go;
    logic [2:0]           sel_idx;
    logic                 active;
    ssl_pkg::ssl_speed_t  raw_tgt, tgt, lin_q;
    logic                 fwd_blk, rev_blk, stop_now, blocked_req;
    logic [6:0]           ucnt_q;
    logic                 utick;
    ssl_pkg::ssl_ratio_t  rate_q, period;
    logic                 away;
    logic [12:0]          bcnt_q;
    ssl_pkg::ssl_ratio_t  wcnt_q;
    logic                 sample;
    ssl_pkg::ssl_speed_t  box_q [BOX_TAPS];
    logic [$clog2(BOX_TAPS)-1:0] ptr_q;
    logic signed [SUMW-1:0] sum_q;
    logic [16:0]          gacc_q;
    ssl_enc_if            eif ();

    // ****************************************************************
    // Register bus
    // ****************************************************************

    // One wait cycle per request, then a single ready cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read | avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    assign wr_go = avs_write && !avs_waitrequest;

    // Configuration registers, written on the accepting edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q     <= 3'h0;
            src_q      <= 2'h0;
            lim_en_q   <= `SSL_RST_LIM_EN;
            stop_sel_q <= `SSL_STOP_BRAKE;
            accel_q    <= 16'h0000;
            decel_q    <= 16'h0000;
            scw_q      <= 16'h0000;
            dnum_q     <= `SSL_RST_RATIO;
            dden_q     <= `SSL_RST_RATIO;
            gnum_q     <= `SSL_RST_RATIO;
            gden_q     <= `SSL_RST_RATIO;
            encdir_q   <= 2'h0;
        end else if (wr_go) begin
            unique case (avs_address)
                `SSL_OFF_MODE:    mode_q <= avs_writedata[2:0];
                `SSL_OFF_SRC:     src_q <= avs_writedata[1:0];
                `SSL_OFF_LIMIT: begin
                    lim_en_q   <= avs_writedata[`SSL_LIM_EN_BIT];
                    stop_sel_q <= avs_writedata[`SSL_STOP_LSB +: 2];
                end
                `SSL_OFF_ACCEL:   accel_q <= avs_writedata[15:0];
                `SSL_OFF_DECEL:   decel_q <= avs_writedata[15:0];
                `SSL_OFF_SCURVE:  scw_q <= avs_writedata[15:0];
                `SSL_OFF_DIVNUM:  dnum_q <= avs_writedata[15:0];
                `SSL_OFF_DIVDEN:  dden_q <= avs_writedata[15:0];
                `SSL_OFF_ENCDIR:  encdir_q <= avs_writedata[1:0];
                `SSL_OFF_GEARNUM: gnum_q <= avs_writedata[15:0];
                `SSL_OFF_GEARDEN: gden_q <= avs_writedata[15:0];
                default: ;
            endcase
        end
    end

    // Preset table; writes are clamped into the legal speed range.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PRESETS; i++) begin
                preset_q[i] <= 16'h0000;
            end
        end else if (wr_go && avs_address[7:5] == `SSL_PRESET_PAGE) begin
            if ($signed(avs_writedata) > `SSL_SPEED_MAX) begin
                preset_q[avs_address[4:2]] <= 16'(`SSL_SPEED_MAX);
            end else if ($signed(avs_writedata) < `SSL_SPEED_MIN) begin
                preset_q[avs_address[4:2]] <= 16'(`SSL_SPEED_MIN);
            end else begin
                preset_q[avs_address[4:2]] <= avs_writedata[15:0];
            end
        end
    end

    // Read mux; unmapped words read as zero.
    always_comb begin
        rd_d = 32'h00000000;
        if (avs_address[7:5] == `SSL_PRESET_PAGE) begin
            rd_d = {{16{preset_q[avs_address[4:2]][15]}}, preset_q[avs_address[4:2]]};
        end else begin
            unique case (avs_address)
                `SSL_OFF_MODE:    rd_d = {29'h0, mode_q};
                `SSL_OFF_SRC:     rd_d = {30'h0, src_q};
                `SSL_OFF_LIMIT:   rd_d = {29'h0, stop_sel_q, lim_en_q};
                `SSL_OFF_ACCEL:   rd_d = {16'h0, accel_q};
                `SSL_OFF_DECEL:   rd_d = {16'h0, decel_q};
                `SSL_OFF_SCURVE:  rd_d = {16'h0, scw_q};
                `SSL_OFF_DIVNUM:  rd_d = {16'h0, dnum_q};
                `SSL_OFF_DIVDEN:  rd_d = {16'h0, dden_q};
                `SSL_OFF_ENCDIR:  rd_d = {30'h0, encdir_q};
                `SSL_OFF_GEARNUM: rd_d = {16'h0, gnum_q};
                `SSL_OFF_GEARDEN: rd_d = {16'h0, gden_q};
                `SSL_OFF_SPEED:   rd_d = {{16{speed_cmd_q[15]}}, speed_cmd_q};
                `SSL_OFF_STATUS:  rd_d = {24'h0, sel_idx, active, blocked_req,
                                          stop_now, rev_blk, fwd_blk};
                default:          rd_d = 32'h00000000;
            endcase
        end
    end

    // Read data is captured as waitrequest falls.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_d;
        end
    end

    // ****************************************************************
    // Target selection and travel limits
    // ****************************************************************

    // Pick the preset and gate it by the travel limits.
    always_comb begin
        sel_idx = {(src_q == `SSL_SRC_EIGHT) & preset_select_bit2, preset_select_bit1, preset_select_bit0};
        active = (mode_q == `SSL_MODE_PRESET) && (src_q == `SSL_SRC_FOUR || src_q == `SSL_SRC_EIGHT);
        raw_tgt = active ? preset_q[sel_idx] : 16'h0000;
        fwd_blk = lim_en_q && !forward_limit_in;
        rev_blk = lim_en_q && !reverse_limit_in;
        blocked_req = (raw_tgt > 0 && fwd_blk) || (raw_tgt < 0 && rev_blk);
        tgt = blocked_req ? 16'h0000 : raw_tgt;
        stop_now = (fwd_blk && lin_q > 0) || (rev_blk && lin_q < 0);
        away = (lin_q >= 0 && tgt > lin_q) || (lin_q <= 0 && tgt < lin_q);
        period = away ? accel_q : decel_q;
    end

    // ****************************************************************
    // Linear ramp
    // ****************************************************************

    // Tick every 2 us: one r/min step per tick at a setting of one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ucnt_q <= 7'h00;
        end else if (ucnt_q == 7'(UTICK - 1)) begin
            ucnt_q <= 7'h00;
        end else begin
            ucnt_q <= ucnt_q + 7'h01;
        end
    end

    assign utick = (ucnt_q == 7'(UTICK - 1));

    // Move one r/min after period ticks; zero period moves one r/min every clock.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lin_q  <= 16'h0000;
            rate_q <= 16'h0000;
        end else if (stop_now) begin
            lin_q  <= 16'h0000;
            rate_q <= 16'h0000;
        end else if (lin_q == tgt) begin
            rate_q <= 16'h0000;
        end else if (period == 16'h0000 || (utick && rate_q >= period - 16'h0001)) begin
            rate_q <= 16'h0000;
            lin_q  <= (tgt > lin_q) ? lin_q + 16'sh0001 : lin_q - 16'sh0001;
        end else if (utick) begin
            rate_q <= rate_q + 16'h0001;
        end
    end

    // ****************************************************************
    // S-curve box filter
    // ****************************************************************

    // Sample the ramp BOX_TAPS times across the S-curve width.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bcnt_q <= 13'h0000;
            wcnt_q <= 16'h0000;
        end else if (bcnt_q == 13'(BOXC - 1)) begin
            bcnt_q <= 13'h0000;
            wcnt_q <= (wcnt_q >= scw_q - 16'h0001) ? 16'h0000 : wcnt_q + 16'h0001;
        end else begin
            bcnt_q <= bcnt_q + 13'h0001;
        end
    end

    assign sample = (bcnt_q == 13'(BOXC - 1)) && (wcnt_q >= scw_q - 16'h0001);

    // Running sum of the window; reset or a stop clears it on the clock edge.
    always_ff @(posedge clk) begin
        if (rst || stop_now) begin
            sum_q <= '0;
            ptr_q <= '0;
            for (int i = 0; i < BOX_TAPS; i++) begin
                box_q[i] <= 16'h0000;
            end
        end else if (sample) begin
            sum_q        <= sum_q + SUMW'(lin_q) - SUMW'(box_q[ptr_q]);
            box_q[ptr_q] <= lin_q;
            ptr_q        <= ptr_q + 1'b1;
        end
    end

    // Final command: filtered unless the width is zero or stopping.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            speed_cmd_q <= 16'h0000;
        end else if (scw_q == 16'h0000 || stop_now) begin
            speed_cmd_q <= stop_now ? 16'h0000 : lin_q;
        end else begin
            speed_cmd_q <= sum_q[SUMW-1 -: 16];
        end
    end

    // Stop method outputs while a limit holds the motor.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dyn_brake_q  <= 1'b0;
            coast_q      <= 1'b0;
            servo_lock_q <= 1'b0;
        end else begin
            dyn_brake_q  <= (stop_now || blocked_req) && stop_sel_q == `SSL_STOP_BRAKE;
            coast_q      <= (stop_now || blocked_req) && stop_sel_q == `SSL_STOP_FREE;
            servo_lock_q <= (stop_now || blocked_req) && stop_sel_q == `SSL_STOP_LOCK;
        end
    end

    // ****************************************************************
    // Electronic gear and encoder output
    // ****************************************************************

    // Accept a pulse only when no steps are pending, then drain.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gacc_q       <= 17'h00000;
            motor_step_q <= 1'b0;
            motor_dir_q  <= 1'b0;
        end else begin
            motor_step_q <= 1'b0;
            if (gden_q != 16'h0000 && gacc_q >= {1'b0, gden_q}) begin
                gacc_q       <= gacc_q - {1'b0, gden_q};
                motor_step_q <= 1'b1;
            end else if (cmd_pulse_in) begin
                gacc_q      <= gacc_q + {1'b0, gnum_q};
                motor_dir_q <= cmd_dir_in;
            end
        end
    end

    // Feed the divider from the encoder or the geared steps.
    // output source
    assign eif.step     = encdir_q[`SSL_OSRC_BIT] ? motor_step_q : enc_step_in;
    assign eif.dir      = encdir_q[`SSL_OSRC_BIT] ? motor_dir_q : enc_dir_in;
    assign eif.index    = enc_index_in;
    assign eif.b_invert = encdir_q[`SSL_BINV_BIT];
    assign eif.num      = dnum_q;
    assign eif.den      = dden_q;

    ssl_enc_div u_div (
        .clk (clk),
        .rst (rst),
        .eif (eif)
    );

    assign enc_a_out = eif.a;
    assign enc_b_out = eif.b;
    assign enc_z_out = eif.z;
endmodule // ssl_top
